// ---- pwmts_pkg.sv ----
// constants, field layouts and carrier types for the timer-select pwm block
// assumes a classic wishbone master with 8-bit data and one system clock
`default_nettype none

package pwmts_pkg;

    // -----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // -----------------------------------------------------------------
    localparam int          IDX_W         = 10;
    localparam logic [9:0]  IDX_CCP_TSEL  = 10'h21e;
    localparam logic [9:0]  IDX_PWM_TSEL  = 10'h21f;
    localparam logic [9:0]  IDX_DUTY_LO0  = 10'h38c;
    localparam logic [9:0]  IDX_DUTY_HI0  = 10'h38d;
    localparam logic [9:0]  IDX_CTRL0     = 10'h38e;
    localparam logic [9:0]  IDX_STRIDE    = 10'h004;

    // -----------------------------------------------------------------
    // reset values and masks
    // -----------------------------------------------------------------
    localparam logic [7:0]  CCP_TSEL_RST  = 8'h55;
    localparam logic [7:0]  PWM_TSEL_RST  = 8'h14;
    localparam logic [7:0]  PWM_TSEL_MASK = 8'h3c;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    localparam logic [1:0]  BITS2_ZERO    = 2'h0;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int          PWM_SEL_LSB   = 2;
    localparam int          DCL_LSB       = 6;
    localparam int          CTRL_EN_BIT   = 7;
    localparam int          CTRL_OUT_BIT  = 5;
    localparam int          CTRL_POL_BIT  = 4;

    // -----------------------------------------------------------------
    // timer select codes
    // -----------------------------------------------------------------
    localparam logic [1:0]  SEL_NONE      = 2'h0;
    localparam logic [1:0]  SEL_FIRST     = 2'h1;
    localparam logic [1:0]  SEL_SECOND    = 2'h2;
    localparam logic [1:0]  SEL_THIRD     = 2'h3;
    localparam int          NUM_TIMERS    = 3;
    localparam int          NUM_CCP       = 4;
    localparam logic [1:0]  PHASE_LAST    = 2'h3;

    // one 8-bit time base timer as seen by the modulators
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] period;
        logic       tick;
        logic [1:0] phase;
    } pwmts_timer_t;

endpackage : pwmts_pkg

`default_nettype wire

// ---- pwmts_core.sv ----
// timer-select registers and two 10-bit pulse-width modulators
// assumes three 8-bit timers clocked at sys clock / 4, wishbone classic
// master, and a sleep level from the power controller
`default_nettype none

module pwmts_core
    import pwmts_pkg::*;
#(
    parameter int NPWM = 2
) (
    // clock and reset
    input  wire logic                      SYS_CLK,
    input  wire logic                      ARST_N,
    // wishbone classic slave
    input  wire logic                      WB_CYC_I,
    input  wire logic                      WB_STB_I,
    input  wire logic                      WB_WE_I,
    input  wire logic [11:0]               WB_ADR_I,
    input  wire logic [0:0]                WB_SEL_I,
    input  wire logic [7:0]                WB_DAT_I,
    output var  logic [7:0]                WB_DAT_O,
    output var  logic                      WB_ACK_O,
    // timers 2, 4 and 6 in that order
    input  wire pwmts_timer_t [NUM_TIMERS-1:0] TIMERS,
    // power state
    input  wire logic                      SLEEP,
    // modulator outputs
    output var  logic [NPWM-1:0]           PWM_OUT,
    // capture/compare timer routing
    output var  logic [7:0]                CCP_TIMER_CHOICE,
    output var  logic [NUM_CCP-1:0]        CCP_TIMER_VALID
);

    // -----------------------------------------------------------------
    // elaboration checks
    // -----------------------------------------------------------------
    // the select register holds two modulator fields only
    if (NPWM < 1 || NPWM > 2) begin : g_bad_npwm
        $error("NPWM must be 1 or 2");
    end

    // -----------------------------------------------------------------
    // bus decode
    // -----------------------------------------------------------------
    logic              ack_q;
    logic              ack_d;
    logic [7:0]        rdata_q;
    logic [7:0]        rdata_d;
    wire logic         bus_req;
    wire logic         bus_wr;
    wire logic [9:0]   bus_idx;
    wire logic         bus_aligned;
    wire logic         hit_ccp_tsel;
    wire logic         hit_pwm_tsel;

    assign bus_req      = WB_CYC_I & WB_STB_I & ~ack_q;
    assign bus_aligned  = (WB_ADR_I[1:0] == BITS2_ZERO);
    assign bus_idx      = WB_ADR_I[11:2];
    assign bus_wr       = bus_req & WB_WE_I & WB_SEL_I[0] & bus_aligned;
    assign hit_ccp_tsel = bus_aligned & (bus_idx == IDX_CCP_TSEL);
    assign hit_pwm_tsel = bus_aligned & (bus_idx == IDX_PWM_TSEL);

    // -----------------------------------------------------------------
    // timer select registers
    // -----------------------------------------------------------------
    logic [7:0]          ccp_timer_select_0_q;
    logic [7:0]          pwm_timer_select_1_q;
    logic [NUM_CCP-1:0]  ccp_valid_q;
    logic [NUM_CCP-1:0]  ccp_valid_d;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ccp_timer_select_0_q <= CCP_TSEL_RST;
            pwm_timer_select_1_q <= PWM_TSEL_RST;
        end else begin
            if (bus_wr && hit_ccp_tsel) begin
                ccp_timer_select_0_q <= WB_DAT_I;
            end
            if (bus_wr && hit_pwm_tsel) begin
                pwm_timer_select_1_q <= WB_DAT_I & PWM_TSEL_MASK;
            end
        end
    end

    // pair choice goes to the capture/compare units; reserved code flagged
    genvar c;
    for (c = 0; c < NUM_CCP; c++) begin : g_ccp
        assign ccp_valid_d[c] =
            (ccp_timer_select_0_q[2*c +: 2] != SEL_NONE);
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ccp_valid_q <= '0;
        end else begin
            ccp_valid_q <= ccp_valid_d;
        end
    end

    // -----------------------------------------------------------------
    // modulators
    // -----------------------------------------------------------------
    logic [NPWM-1:0]   out_q;
    logic [NPWM-1:0]   out_d;
    logic [7:0]        mod_rdata [NPWM];
    logic [NPWM-1:0]   mod_hit;

    genvar m;
    for (m = 0; m < NPWM; m++) begin : g_pwm
        localparam logic [9:0] IDX_OFF = 10'(IDX_STRIDE * m);
        localparam logic [9:0] I_LO    = IDX_DUTY_LO0 + IDX_OFF;
        localparam logic [9:0] I_HI    = IDX_DUTY_HI0 + IDX_OFF;
        localparam logic [9:0] I_CTRL  = IDX_CTRL0 + IDX_OFF;

        // software-visible registers
        logic [1:0]    duty_low_bits_q;
        logic [7:0]    duty_high_byte_q;
        logic          enable_q;
        logic          invert_output_q;
        // buffered duty and raw waveform
        logic [9:0]    duty_buf_q;
        logic [9:0]    duty_buf_d;
        logic          raw_q;
        logic          raw_d;

        wire logic     hit_lo;
        wire logic     hit_hi;
        wire logic     hit_ctrl;
        wire logic [1:0]   modulator_timer_choice;
        wire pwmts_timer_t sel_tmr;
        wire logic     tmr_valid;
        wire logic [9:0]   time_base;
        wire logic [9:0]   duty_value;
        wire logic [10:0]  period_span;
        wire logic     period_event;
        wire logic     never_clear;
        wire logic     duty_match;

        assign hit_lo   = bus_aligned & (bus_idx == I_LO);
        assign hit_hi   = bus_aligned & (bus_idx == I_HI);
        assign hit_ctrl = bus_aligned & (bus_idx == I_CTRL);
        assign mod_hit[m] = hit_lo | hit_hi | hit_ctrl;

        // timer routing for this modulator
        assign modulator_timer_choice =
            pwm_timer_select_1_q[PWM_SEL_LSB + 2*m +: 2];
        assign tmr_valid = (modulator_timer_choice != SEL_NONE);
        // reserved code routes no timer, so the modulator simply stops
        assign sel_tmr =
            (modulator_timer_choice == SEL_FIRST)  ? TIMERS[0] :
            (modulator_timer_choice == SEL_SECOND) ? TIMERS[1] :
            (modulator_timer_choice == SEL_THIRD)  ? TIMERS[2] :
                                                     '0;

        // count extended by the two fast phase bits
        assign time_base = {sel_tmr.count, sel_tmr.phase};
        assign duty_value = {duty_high_byte_q,
                             duty_low_bits_q};

        // tick is the pre-postscaler increment, one per (prescale*4) clocks
        assign period_event = tmr_valid & sel_tmr.tick &
            (sel_tmr.count == sel_tmr.period);

        // 4*(period+1): a buffered duty at or past this cannot be reached
        assign period_span = {1'b0, sel_tmr.period, PHASE_LAST} +
                             11'h001;
        assign never_clear = ({1'b0, duty_buf_q} >=
                              period_span);
        assign duty_match  = tmr_valid & (time_base == duty_buf_q) &
                             ~never_clear;

        // waveform next state; sleep freezes everything
        always_comb begin
            duty_buf_d = duty_buf_q;
            raw_d      = raw_q;
            if (!SLEEP) begin
                if (period_event) begin
                    duty_buf_d = duty_value;
                    raw_d      = (duty_value != '0);
                end else if (duty_match) begin
                    raw_d = 1'b0;
                end
            end
        end

        // pin level: disabled shows inactive level after polarity
        always_comb begin
            out_d[m] = out_q[m];
            if (!SLEEP) begin
                out_d[m] = (enable_q & raw_d) ^
                           invert_output_q;
            end
        end

        always_ff @(posedge SYS_CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                duty_low_bits_q  <= BITS2_ZERO;
                duty_high_byte_q <= BYTE_ZERO;
                enable_q         <= 1'b0;
                invert_output_q  <= 1'b0;
            end else begin
                // duty writes land in the shadow copy at any time; control writes take effect at once
                if (bus_wr && hit_lo) begin
                    duty_low_bits_q <= WB_DAT_I[DCL_LSB +: 2];
                end
                if (bus_wr && hit_hi) begin
                    duty_high_byte_q <= WB_DAT_I;
                end
                if (bus_wr && hit_ctrl) begin
                    enable_q        <= WB_DAT_I[CTRL_EN_BIT];
                    invert_output_q <= WB_DAT_I[CTRL_POL_BIT];
                end
            end
        end

        always_ff @(posedge SYS_CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                duty_buf_q <= '0;
                raw_q      <= 1'b0;
            end else begin
                duty_buf_q <= duty_buf_d;
                raw_q      <= raw_d;
            end
        end

        // read-back mux for this modulator
        always_comb begin
            mod_rdata[m] = BYTE_ZERO;
            if (hit_lo) begin
                mod_rdata[m][DCL_LSB +: 2] = duty_low_bits_q;
            end else if (hit_hi) begin
                mod_rdata[m] = duty_high_byte_q;
            end else if (hit_ctrl) begin
                mod_rdata[m][CTRL_EN_BIT]  = enable_q;
                mod_rdata[m][CTRL_OUT_BIT] = out_q[m];
                mod_rdata[m][CTRL_POL_BIT] = invert_output_q;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    // -----------------------------------------------------------------
    // read data and acknowledge
    // -----------------------------------------------------------------
    // unmapped or misaligned addresses still ack and read zero
    always_comb begin
        rdata_d = BYTE_ZERO;
        if (hit_ccp_tsel) begin
            rdata_d = ccp_timer_select_0_q;
        end else if (hit_pwm_tsel) begin
            rdata_d = pwm_timer_select_1_q;
        end else begin
            for (int k = 0; k < NPWM; k++) begin
                if (mod_hit[k]) begin
                    rdata_d = mod_rdata[k];
                end
            end
        end
    end

    assign ack_d = bus_req;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_q   <= 1'b0;
            rdata_q <= BYTE_ZERO;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= bus_req ? rdata_d : BYTE_ZERO;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign WB_ACK_O         = ack_q;
    assign WB_DAT_O         = rdata_q;
    assign PWM_OUT          = out_q;
    assign CCP_TIMER_CHOICE = ccp_timer_select_0_q;
    assign CCP_TIMER_VALID  = ccp_valid_q;

endmodule : pwmts_core

`default_nettype wire

// ---- pwmts_assertions.sv ----
// bus and routing checks for the timer-select pwm block
// assumes the one-cycle registered ack described for pwmts_core
`default_nettype none

module pwmts_assertions
    import pwmts_pkg::*;
#(
    parameter int NPWM = 2
) (
    // clock and reset
    input wire logic                 SYS_CLK,
    input wire logic                 ARST_N,
    // bus
    input wire logic                 WB_CYC_I,
    input wire logic                 WB_STB_I,
    input wire logic                 WB_WE_I,
    input wire logic [11:0]          WB_ADR_I,
    input wire logic [0:0]           WB_SEL_I,
    input wire logic [7:0]           WB_DAT_I,
    input wire logic [7:0]           WB_DAT_O,
    input wire logic                 WB_ACK_O,
    // power and outputs
    input wire logic                 SLEEP,
    input wire logic [NPWM-1:0]      PWM_OUT,
    input wire logic [7:0]           CCP_TIMER_CHOICE,
    input wire logic [NUM_CCP-1:0]   CCP_TIMER_VALID
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    wire logic req = WB_CYC_I & WB_STB_I & !WB_ACK_O;
    wire logic sel_wr = req & WB_WE_I & WB_SEL_I[0]
                        & (WB_ADR_I == {IDX_CCP_TSEL, 2'b00});
    wire logic [NUM_CCP-1:0] valid_exp;
    for (genvar c = 0; c < NUM_CCP; c++) begin : g_valid
        assign valid_exp[c] = |CCP_TIMER_CHOICE[2*c +: 2];
    end

    sequence s_req; req; endsequence
    sequence s_ack; WB_ACK_O ##1 !WB_ACK_O; endsequence

    property p_ack_resp; s_req |=> s_ack; endproperty
    property p_ack_cause; WB_ACK_O |-> $past(req); endproperty
    property p_no_req; !(WB_CYC_I & WB_STB_I) |=> !WB_ACK_O; endproperty
    property p_dat_idle; !WB_ACK_O |-> WB_DAT_O == BYTE_ZERO; endproperty
    property p_valid;
        1'b1 |=> CCP_TIMER_VALID == $past(valid_exp);
    endproperty
    property p_choice_wr;
        sel_wr |=> CCP_TIMER_CHOICE == $past(WB_DAT_I);
    endproperty
    property p_choice_hold; !sel_wr |=> $stable(CCP_TIMER_CHOICE); endproperty
    property p_sleep_hold; SLEEP |=> $stable(PWM_OUT); endproperty

    a_ack_resp: assert property (p_ack_resp)
        else $error("ack missing or too long");
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    a_no_req: assert property (p_no_req)
        else $error("ack while idle");
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data outside ack");
    a_valid: assert property (p_valid)
        else $error("select valid flags wrong");
    a_choice_wr: assert property (p_choice_wr)
        else $error("select write lost");
    a_choice_hold: assert property (p_choice_hold)
        else $error("select changed without write");
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("output moved in sleep");
endmodule : pwmts_assertions

bind pwmts_core pwmts_assertions #(.NPWM(NPWM)) pwmts_assertions_i (
    .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .SLEEP(SLEEP), .PWM_OUT(PWM_OUT),
    .CCP_TIMER_CHOICE(CCP_TIMER_CHOICE), .CCP_TIMER_VALID(CCP_TIMER_VALID));

`default_nettype wire

// ---- pwmts_timer_model.sv ----
// three 8-bit time base timers feeding the modulators
// assumes prescale 1:1, so the low time-base bits are the clock phase
`default_nettype none

module pwmts_timer_model
    import pwmts_pkg::*;
#(
    parameter logic [7:0] PER2 = 8'h03,
    parameter logic [7:0] PER4 = 8'h01,
    parameter logic [7:0] PER6 = 8'h02
) (
    // clock, reset, power
    input  wire logic                          SYS_CLK,
    input  wire logic                          ARST_N,
    input  wire logic                          SLEEP,
    // timer views
    output var  pwmts_timer_t [NUM_TIMERS-1:0] TIMERS
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] PER [NUM_TIMERS] = '{PER2, PER4, PER6};
    logic [1:0] phase_q;
    logic [7:0] count_q [NUM_TIMERS];

    // timer runs at sys clock / 4; tick is taken before any postscaler
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            phase_q <= 2'h0;
            count_q <= '{default: 8'h00};
        end else if (!SLEEP) begin
            phase_q <= phase_q + 2'h1;
            for (int t = 0; t < NUM_TIMERS; t++) begin
                if (phase_q == PHASE_LAST) begin
                    count_q[t] <= (count_q[t] >= PER[t]) ? 8'h00
                                                         : count_q[t] + 8'h01;
                end
            end
        end
    end

    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
        assign TIMERS[t] = '{count: count_q[t], period: PER[t],
                             tick: (phase_q == PHASE_LAST) && !SLEEP,
                             phase: phase_q};
    end
endmodule : pwmts_timer_model

`default_nettype wire

// ---- test_pwmts_core.sv ----
// self-checking bench for pwmts_core: registers, waveforms, sleep
// assumes the timer model runs with fixed periods 3, 1 and 2
`default_nettype none

module test_pwmts_core
    import pwmts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] PER [3] = '{8'h03, 8'h01, 8'h02};
    logic                          clk = 1'b0;
    logic                          arst_n = 1'b0;
    logic                          cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic                          sleep = 1'b0;
    logic [11:0]                   adr = 12'h000;
    logic [0:0]                    sel = 1'b1;
    logic [7:0]                    dat = 8'h00, dat_o;
    logic                          ack;
    pwmts_timer_t [NUM_TIMERS-1:0] timers;
    logic [1:0]                    pwm_out;
    logic [7:0]                    ccp_choice;
    logic [NUM_CCP-1:0]            ccp_valid;
    int                            err_count = 0, total_checks = 0;

    always #25 clk = ~clk;

    pwmts_timer_model #(.PER2(PER[0]), .PER4(PER[1]), .PER6(PER[2]))
        pwmts_timer_model_i (.SYS_CLK(clk), .ARST_N(arst_n), .SLEEP(sleep),
                             .TIMERS(timers));
    pwmts_core #(.NPWM(2)) pwmts_core_i (
        .SYS_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .TIMERS(timers), .SLEEP(sleep),
        .PWM_OUT(pwm_out), .CCP_TIMER_CHOICE(ccp_choice),
        .CCP_TIMER_VALID(ccp_valid));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [9:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
        int n;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; dat <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n >= 20) begin
            err_count++;
            $display("Error at %0t: bus timeout", $time);
            wrap_up();
        end
    endtask : wb

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, idx, d, r);
    endtask : wr

    task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
        logic [7:0] r;
        wb(1'b0, idx, 8'h00, r);
        chk({8'h00, r}, {8'h00, e});
    endtask : rdc

    task automatic meas(input int n, output int h0, output int h1);
        h0 = 0;
        h1 = 0;
        repeat (n) begin
            @(posedge clk);
            if (pwm_out[0] === 1'b1) h0++;
            if (pwm_out[1] === 1'b1) h1++;
        end
    endtask : meas

    // high cycles in one period: set at restart, cleared one past duty
    function automatic int hi_exp(int d, int n, logic p);
        int h;
        h = (d == 0) ? 0 : ((d + 1 < n) ? d + 1 : n);
        return p ? n - h : h;
    endfunction : hi_exp

    initial begin
        static logic [9:0] ridx [7] = '{IDX_CCP_TSEL, IDX_PWM_TSEL,
            IDX_DUTY_LO0, IDX_DUTY_HI0, IDX_CTRL0, IDX_CTRL0 + IDX_STRIDE,
            10'h000};
        static logic [7:0] rrst [7] = '{CCP_TSEL_RST, PWM_TSEL_RST, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00};
        static int c_sel [3] = '{1, 2, 3};
        static int c_d0 [3] = '{5, 8, 1};
        static int c_d1 [3] = '{0, 3, 20};
        static logic c_p1 [3] = '{1'b0, 1'b1, 1'b0};
        int h0, h1, n;
        logic [1:0] o;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rdc(ridx[i], rrst[i]);
        chk({8'h00, ccp_choice}, {8'h00, CCP_TSEL_RST});
        chk(16'(ccp_valid), 16'h000f);
        wr(IDX_PWM_TSEL, 8'hff);
        rdc(IDX_PWM_TSEL, PWM_TSEL_MASK);
        wr(IDX_DUTY_LO0, 8'hff);
        rdc(IDX_DUTY_LO0, 8'hc0);
        wr(IDX_CCP_TSEL, 8'h1b);
        repeat (2) @(posedge clk);
        chk({8'h00, ccp_choice}, 16'h001b);
        chk(16'(ccp_valid), 16'h0007);
        $display("register test done");
        for (int k = 0; k < 3; k++) begin
            n = 4 * (int'(PER[c_sel[k] - 1]) + 1);
            wr(IDX_PWM_TSEL, 8'(c_sel[k] * 'h14));
            wr(IDX_DUTY_LO0, 8'(c_d0[k] << 6));
            wr(IDX_DUTY_HI0, 8'(c_d0[k] >> 2));
            wr(IDX_DUTY_LO0 + IDX_STRIDE, 8'(c_d1[k] << 6));
            wr(IDX_DUTY_HI0 + IDX_STRIDE, 8'(c_d1[k] >> 2));
            wr(IDX_CTRL0, 8'h80);
            wr(IDX_CTRL0 + IDX_STRIDE, {3'h4, c_p1[k], 4'h0});
            repeat (3 * n) @(posedge clk);
            meas(n, h0, h1);
            chk(16'(h0), 16'(hi_exp(c_d0[k], n, 1'b0)));
            chk(16'(h1), 16'(hi_exp(c_d1[k], n, c_p1[k])));
            if (k == 1) rdc(IDX_CTRL0, 8'ha0);
            sleep <= 1'b1;
            @(posedge clk);
            o = pwm_out;
            repeat (10) begin
                @(posedge clk);
                chk(16'(pwm_out), 16'(o));
            end
            sleep <= 1'b0;
            $display("waveform case %0d done", k);
        end
        wr(IDX_CTRL0, 8'h10);
        wr(IDX_CTRL0 + IDX_STRIDE, 8'h00);
        repeat (n) @(posedge clk);
        meas(n, h0, h1);
        chk(16'(h0), 16'(n));
        chk(16'(h1), 16'h0000);
        $display("disable test done");
        wrap_up();
    end
endmodule : test_pwmts_core

`default_nettype wire
